/* File: rtl/pin_mapper_pkg.sv */
package pin_mapper_pkg;

  localparam int NUM_CH = 3;

  // input function codes
  localparam logic [3:0] GPI_DEEP_SLEEP  = 4'h0;
  localparam logic [3:0] GPI_FAULT_DUMP  = 4'h2;
  localparam logic [3:0] GPI_POWERDOWN   = 4'h4;
  localparam logic [3:0] GPI_PROTECT     = 4'h5;
  localparam logic [3:0] GPI_FUNC_GEN    = 4'h6;
  localparam logic [3:0] GPI_CLEAR       = 4'h7;
  localparam logic [3:0] GPI_SYNC_LOAD   = 4'h8;
  localparam logic [3:0] GPI_MARGIN      = 4'hA;
  localparam logic [3:0] GPI_RESET       = 4'hB;
  localparam logic [3:0] GPI_NVM_GATE    = 4'hC;
  localparam logic [3:0] GPI_REG_GATE    = 4'hD;

  // output status codes
  localparam logic [3:0] GPO_NV_BUSY     = 4'h1;
  localparam logic [3:0] GPO_CH2_BUSY    = 4'h4;
  localparam logic [3:0] GPO_CH0_BUSY    = 4'h6;
  localparam logic [3:0] GPO_CH1_BUSY    = 4'h7;
  localparam logic [3:0] GPO_WIN_CMP     = 4'hB;

  // reset values of the volatile selection and of the gate/hold states
  localparam logic [3:0] CODE_RESET      = 4'h0;
  localparam logic       ENABLE_RESET    = 1'b0;
  localparam logic       GATE_RESET      = 1'b1;
  localparam logic       PIN_RESET       = 1'b1;

  // boot sequencer
  typedef enum logic [1:0] {
    BOOT_LOAD   = 2'b00,
    BOOT_SAMPLE = 2'b01,
    BOOT_RUN    = 2'b11
  } boot_state_e;

endpackage

/* File: rtl/pin_edge_detect.sv */
`timescale 1ns/10ps
// registered edge detector; the previous level is tracked through boot while preset masks edges, so that
// the first run cycle after boot sees no spurious edge
module pin_edge_detect
  import pin_mapper_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin_level,
  input  wire logic preset,
  output logic      fall,
  output logic      rise
);

  logic prev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev <= PIN_RESET;
    end else begin
      prev <= pin_level;
    end
  end

  always_comb begin
    fall = !preset && prev && !pin_level;
    rise = !preset && !prev && pin_level;
  end

endmodule

/* File: rtl/multifunction_pin_mapper.sv */
`timescale 1ns/10ps
// Overview of operation
// RULE1: the board ties the shared pin high or low when it is unused.
// RULE2: a selection held only in volatile settings is lost on reset; nonvolatile one is restored.
// RULE3: code 0000 enters deep sleep on a falling edge and leaves it on a rising edge.
// RULE4: code 0100 powers down selected channels on a fall and powers them up on a rise.
// RULE5: code 1000 fires a synchronous load of selected channels on a fall only.
// RULE6: code 1011 starts a device reset on a low pulse; it works only from nonvolatile memory.
// RULE7: code 1101 allows register map updates on a falling edge.
// RULE8: code 1101 blocks register writes after a rise, except unlock writes and two-wire resets.
// RULE9: codes 0010, 0101 and 0111 fire fault dump, protect and clear on a fall; others do nothing.
// RULE10: in output mode the pin shows the status chosen by the output code.
// RULE11: further codes start/stop waveforms, margin high/low and gate nonvolatile programming.
// RULE12: input and output enables pick direction; channel functions use the channel select.
// RULE13: after power-up the pin level is sampled once and acted on; later only edges count.
// RULE14: the pin defaults to no function and a mapped input disables the matching software bit.
module multifunction_pin_mapper
  import pin_mapper_pkg::*;
#(
  parameter int CH = NUM_CH
)
(
  input  wire logic          clk,
  input  wire logic          resetn,
  // shared pin, three signals
  input  wire logic          shared_multi_pin_in,
  output logic               shared_multi_pin_out,
  output logic               shared_multi_pin_oe,
  // nonvolatile image of the selection, restored at every reset
  input  wire logic          nvm_input_enable_bit,
  input  wire logic          nvm_output_enable_bit,
  input  wire logic [3:0]    nvm_input_function_code,
  input  wire logic [3:0]    nvm_output_function_code,
  input  wire logic [CH-1:0] nvm_input_channel_select,
  // volatile writes of the selection
  input  wire logic          cfg_write,
  input  wire logic          input_enable_bit,
  input  wire logic          output_enable_bit,
  input  wire logic [3:0]    input_function_code,
  input  wire logic [3:0]    output_function_code,
  input  wire logic [CH-1:0] input_channel_select,
  // status sources
  input  wire logic          nonvolatile_busy_status,
  input  wire logic [CH-1:0] channel_busy,
  input  wire logic          window_comparator_result,
  // register write gate
  input  wire logic          reg_write_req,
  input  wire logic          reg_write_unlock_field,
  input  wire logic          reg_write_reset_two_wire,
  output logic               reg_write_allow,
  // actions
  output logic               deep_sleep,
  output logic               fault_dump_pulse,
  output logic               protect_pulse,
  output logic               output_clear_action,
  output logic [CH-1:0]      synchronous_load_strobe,
  output logic [CH-1:0]      channel_powerdown,
  output logic [CH-1:0]      func_gen_run,
  output logic [CH-1:0]      margin_high,
  output logic [CH-1:0]      margin_low,
  output logic               nvm_program_allow,
  output logic               device_reset_pulse,
  output logic               boot_done,
  // software bit disables while the pin owns the function
  output logic               sw_deep_sleep_disable,
  output logic               sw_powerdown_disable,
  output logic               sw_sync_load_disable,
  output logic               sw_clear_disable,
  output logic               sw_func_gen_disable
);

  boot_state_e     boot_state;
  logic            in_en;
  logic            out_en;
  logic [3:0]      gpi_code;
  logic [3:0]      gpo_code;
  logic [CH-1:0]   ch_sel;
  logic            fall;
  logic            rise;
  logic            boot_sample;
  logic            act_fall;
  logic            act_rise;
  logic            in_mode;
  logic            reset_armed;
  logic            reg_gate_open;
  logic            next_pin_out;

  assign in_mode     = in_en && !out_en;
  assign boot_sample = (boot_state == BOOT_SAMPLE);
  // at boot a low level acts as a fall and a high level as a rise
  assign act_fall    = in_mode && (fall || (boot_sample && !shared_multi_pin_in));  // see RULE13
  assign act_rise    = in_mode && (rise || (boot_sample && shared_multi_pin_in));   // see RULE13

  pin_edge_detect u_edge (
    .clk       (clk),
    .resetn    (resetn),
    .pin_level (shared_multi_pin_in),
    .preset    (boot_state != BOOT_RUN),
    .fall      (fall),
    .rise      (rise)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_state <= BOOT_LOAD;
    end else begin
      case (boot_state)
        BOOT_LOAD:   boot_state <= BOOT_SAMPLE;
        BOOT_SAMPLE: boot_state <= BOOT_RUN;
        BOOT_RUN:    boot_state <= BOOT_RUN;
        default:     boot_state <= BOOT_LOAD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_done <= 1'b0;
    end else begin
      boot_done <= (boot_state == BOOT_RUN);
    end
  end

  // reset wipes the volatile selection; the nonvolatile image is taken after release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_en    <= ENABLE_RESET;  // see RULE14
      out_en   <= ENABLE_RESET;
      gpi_code <= CODE_RESET;
      gpo_code <= CODE_RESET;
      ch_sel   <= '0;
    end else if (boot_state == BOOT_LOAD) begin
      in_en    <= nvm_input_enable_bit;  // see RULE2
      out_en   <= nvm_output_enable_bit;
      gpi_code <= nvm_input_function_code;
      gpo_code <= nvm_output_function_code;
      ch_sel   <= nvm_input_channel_select;
    end else if (cfg_write) begin
      in_en    <= input_enable_bit;  // see RULE12
      out_en   <= output_enable_bit;
      gpi_code <= input_function_code;
      gpo_code <= output_function_code;
      ch_sel   <= input_channel_select;
    end
  end

  // reset only counts when the mapping came from nonvolatile storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_armed <= 1'b0;
    end else if (boot_state == BOOT_LOAD) begin
      reset_armed <= nvm_input_enable_bit && (nvm_input_function_code == GPI_RESET);
    end else if (cfg_write) begin
      reset_armed <= 1'b0;  // see RULE6
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      device_reset_pulse <= 1'b0;
    end else begin
      // only a real falling edge; a boot-time low must not loop resets
      device_reset_pulse <= reset_armed && in_mode && fall && (gpi_code == GPI_RESET);  // see RULE6
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      deep_sleep <= 1'b0;
    end else if (gpi_code == GPI_DEEP_SLEEP) begin
      if (act_fall) deep_sleep <= 1'b1;  // see RULE3
      else if (act_rise) deep_sleep <= 1'b0;  // see RULE3
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_dump_pulse    <= 1'b0;
      protect_pulse       <= 1'b0;
      output_clear_action <= 1'b0;
    end else begin
      fault_dump_pulse    <= act_fall && (gpi_code == GPI_FAULT_DUMP);  // see RULE9
      protect_pulse       <= act_fall && (gpi_code == GPI_PROTECT);     // see RULE9
      output_clear_action <= act_fall && (gpi_code == GPI_CLEAR);       // see RULE9
    end
  end

  for (genvar c = 0; c < CH; c++) begin : g_ch
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        synchronous_load_strobe[c] <= 1'b0;
        channel_powerdown[c]       <= 1'b0;
        func_gen_run[c]            <= 1'b0;
        margin_high[c]             <= 1'b0;
        margin_low[c]              <= 1'b0;
      end else begin
        synchronous_load_strobe[c] <= act_fall && ch_sel[c] && (gpi_code == GPI_SYNC_LOAD);  // see RULE5
        margin_high[c] <= act_rise && ch_sel[c] && (gpi_code == GPI_MARGIN);  // see RULE11
        margin_low[c]  <= act_fall && ch_sel[c] && (gpi_code == GPI_MARGIN);  // see RULE11
        if (ch_sel[c] && gpi_code == GPI_POWERDOWN) begin
          if (act_fall) channel_powerdown[c] <= 1'b1;  // see RULE4
          else if (act_rise) channel_powerdown[c] <= 1'b0;  // see RULE4
        end
        if (ch_sel[c] && gpi_code == GPI_FUNC_GEN) begin
          if (act_rise) func_gen_run[c] <= 1'b1;  // see RULE11
          else if (act_fall) func_gen_run[c] <= 1'b0;  // see RULE11
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvm_program_allow <= GATE_RESET;
    end else if (gpi_code == GPI_NVM_GATE) begin
      if (act_fall) nvm_program_allow <= 1'b1;  // see RULE11
      else if (act_rise) nvm_program_allow <= 1'b0;  // see RULE11
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_gate_open <= GATE_RESET;
    end else if (gpi_code != GPI_REG_GATE || !in_mode) begin
      reg_gate_open <= 1'b1;
    end else if (act_fall) begin
      reg_gate_open <= 1'b1;  // see RULE7
    end else if (act_rise) begin
      reg_gate_open <= 1'b0;  // see RULE8
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_write_allow <= 1'b0;
    end else begin
      reg_write_allow <= reg_write_req && (reg_gate_open || reg_write_unlock_field
                         || reg_write_reset_two_wire);  // see RULE8
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_deep_sleep_disable <= 1'b0;
      sw_powerdown_disable  <= 1'b0;
      sw_sync_load_disable  <= 1'b0;
      sw_clear_disable      <= 1'b0;
      sw_func_gen_disable   <= 1'b0;
    end else begin
      sw_deep_sleep_disable <= in_mode && (gpi_code == GPI_DEEP_SLEEP);  // see RULE14
      sw_powerdown_disable  <= in_mode && (gpi_code == GPI_POWERDOWN);   // see RULE14
      sw_sync_load_disable  <= in_mode && (gpi_code == GPI_SYNC_LOAD);   // see RULE14
      sw_clear_disable      <= in_mode && (gpi_code == GPI_CLEAR);       // see RULE14
      sw_func_gen_disable   <= in_mode && (gpi_code == GPI_FUNC_GEN);    // see RULE14
    end
  end

  always_comb begin
    case (gpo_code)
      GPO_NV_BUSY:  next_pin_out = nonvolatile_busy_status;  // see RULE10
      GPO_CH2_BUSY: next_pin_out = channel_busy[2];          // see RULE10
      GPO_CH0_BUSY: next_pin_out = channel_busy[0];          // see RULE10
      GPO_CH1_BUSY: next_pin_out = channel_busy[1];          // see RULE10
      GPO_WIN_CMP:  next_pin_out = window_comparator_result; // see RULE10
      default:      next_pin_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shared_multi_pin_out <= 1'b0;
      shared_multi_pin_oe  <= 1'b0;
    end else begin
      shared_multi_pin_out <= next_pin_out;
      shared_multi_pin_oe  <= out_en && (boot_state == BOOT_RUN);  // see RULE12
    end
  end

endmodule

/* File: tb/pin_board.sv */
`timescale 1ns/10ps
module pin_board (
  input  wire logic level,
  input  wire logic drive_oe,
  input  wire logic drive_out,
  output logic      pin_in
);
  // board ties the pin to a level whenever the block is not driving it
  assign pin_in = drive_oe ? drive_out : level;
endmodule

/* File: tb/multifunction_pin_mapper_asserts.sv */
`timescale 1ns/10ps
module multifunction_pin_mapper_asserts
  import pin_mapper_pkg::*;
#(parameter int CH = NUM_CH)
(
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic          shared_multi_pin_in,
  input wire logic          nvm_input_enable_bit,
  input wire logic          nvm_output_enable_bit,
  input wire logic [3:0]    nvm_input_function_code,
  input wire logic [CH-1:0] nvm_input_channel_select,
  input wire logic          cfg_write,
  input wire logic          input_enable_bit,
  input wire logic          output_enable_bit,
  input wire logic [3:0]    input_function_code,
  input wire logic [CH-1:0] input_channel_select,
  input wire logic          reg_write_req,
  input wire logic          reg_write_unlock_field,
  input wire logic          reg_write_reset_two_wire,
  input wire logic          reg_write_allow,
  input wire logic          deep_sleep,
  input wire logic          fault_dump_pulse,
  input wire logic          protect_pulse,
  input wire logic          output_clear_action,
  input wire logic [CH-1:0] synchronous_load_strobe,
  input wire logic [CH-1:0] channel_powerdown,
  input wire logic          device_reset_pulse,
  input wire logic          boot_done
);
  logic [1:0]    bc;
  logic [3:0]    ic, fc;
  logic [CH-1:0] cs, fs;
  logic          im, nv, pp, fl, rs, lk, fm;
  // lock after a rise and hold until a fall, as the gate does; leaving the code or input mode reopens it
  wire lkn = fm && fc == GPI_REG_GATE && (rs || (lk && !fl));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bc <= 2'h0;
      ic <= 4'h0;
      cs <= '0;
      im <= 1'b0;
      nv <= 1'b0;
    end else begin
      if (bc != 2'h3) bc <= bc + 2'h1;
      if (bc == 2'h0) begin
        ic <= nvm_input_function_code;
        cs <= nvm_input_channel_select;
        im <= nvm_input_enable_bit && !nvm_output_enable_bit;
        nv <= 1'b1;
      end else if (cfg_write) begin
        ic <= input_function_code;
        cs <= input_channel_select;
        im <= input_enable_bit && !output_enable_bit;
        nv <= 1'b0;
      end
    end
  end
  // the boot sample acts as an edge, run mode starts one cycle before boot_done
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pp <= 1'b1;
      fl <= 1'b0;
      rs <= 1'b0;
      fm <= 1'b0;
      fc <= 4'h0;
      fs <= '0;
      lk <= 1'b0;
    end else begin
      pp <= shared_multi_pin_in;
      fl <= im && !shared_multi_pin_in && (bc[1] ? pp : bc[0]);
      rs <= im && shared_multi_pin_in && (bc[1] ? !pp : bc[0]);
      fm <= im;
      fc <= ic;
      fs <= cs;
      lk <= lkn;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_fall(logic [3:0] c); fl && fc == c; endsequence
  sequence s_edge(logic [3:0] c); (fl || rs) && fc == c; endsequence
  a_boot_done_time: assert property (boot_done == (bc == 2'h3))
    else $error("boot_done out of step with boot sequence");
  a_clear_on_fall: assert property (s_fall(GPI_CLEAR) |-> output_clear_action)
    else $error("clear missing after fall");
  a_fault_on_fall: assert property (s_fall(GPI_FAULT_DUMP) |-> fault_dump_pulse && !protect_pulse)
    else $error("fault dump wrong after fall");
  a_sleep_follows_pin: assert property (s_edge(GPI_DEEP_SLEEP) |-> deep_sleep == fl)
    else $error("deep sleep does not follow pin");
  a_pdn_follows_pin: assert property (s_edge(GPI_POWERDOWN) |-> (channel_powerdown & fs) == (fl ? fs : '0))
    else $error("powerdown does not follow pin");
  a_load_fall_only: assert property (s_edge(GPI_SYNC_LOAD) |-> synchronous_load_strobe == (fl ? fs : '0))
    else $error("load strobe wrong");
  a_reset_from_nvm: assert property (device_reset_pulse |-> fl && fc == GPI_RESET && nv)
    else $error("reset pulse without nonvolatile mapping");
  a_gate_blocked: assert property (reg_write_req && lkn && !reg_write_unlock_field
    && !reg_write_reset_two_wire |=> !reg_write_allow)
    else $error("write allowed while blocked");
  a_gate_open_write: assert property (reg_write_req && !lkn |=> reg_write_allow)
    else $error("write refused while open");
endmodule

/* File: tb/test_multifunction_pin_mapper.sv */
`timescale 1ns/10ps
module test_multifunction_pin_mapper;
  import pin_mapper_pkg::*;
  logic clk, resetn, shared_multi_pin_in, lvl, cfg_write, input_enable_bit, output_enable_bit;
  logic nvm_input_enable_bit, nvm_output_enable_bit, nonvolatile_busy_status, a;
  logic window_comparator_result, reg_write_req, reg_write_unlock_field, reg_write_reset_two_wire;
  logic [3:0] nvm_input_function_code, nvm_output_function_code, input_function_code;
  logic [3:0] output_function_code;
  logic [NUM_CH-1:0] nvm_input_channel_select, input_channel_select, channel_busy;
  logic shared_multi_pin_out, shared_multi_pin_oe, reg_write_allow, deep_sleep, fault_dump_pulse;
  logic protect_pulse, output_clear_action, nvm_program_allow, device_reset_pulse, boot_done;
  logic sw_deep_sleep_disable, sw_powerdown_disable, sw_sync_load_disable, sw_clear_disable;
  logic sw_func_gen_disable;
  logic [NUM_CH-1:0] synchronous_load_strobe, channel_powerdown, func_gen_run, margin_high;
  logic [NUM_CH-1:0] margin_low;
  logic [3:0] pc [4] = '{GPI_FAULT_DUMP, GPI_PROTECT, GPI_CLEAR, 4'hF};
  logic [3:0] oc [6] = '{GPO_NV_BUSY, GPO_CH2_BUSY, GPO_CH0_BUSY, GPO_CH1_BUSY, GPO_WIN_CMP, 4'h2};
  int num_errors = 0;
  int n_checks = 0;
  multifunction_pin_mapper uut (.*);
  pin_board board (.level(lvl), .drive_oe(shared_multi_pin_oe),
    .drive_out(shared_multi_pin_out), .pin_in(shared_multi_pin_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task do_reset(input logic pv, input logic ie, input logic [3:0] ic);
    @(posedge clk);
    resetn <= 1'b0;
    lvl <= pv;
    nvm_input_enable_bit <= ie;
    nvm_input_function_code <= ic;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    cyc(5);
  endtask
  task setcfg(input logic ie, oe, input logic [3:0] ic, oc, input logic [NUM_CH-1:0] cs);
    @(posedge clk);
    cfg_write <= 1'b1;
    input_enable_bit <= ie;
    output_enable_bit <= oe;
    input_function_code <= ic;
    output_function_code <= oc;
    input_channel_select <= cs;
    @(posedge clk);
    cfg_write <= 1'b0;
    cyc(2);
  endtask
  // the action shows one cycle after the change is seen, and a pulse lasts one cycle
  task edge_to(input logic v);
    @(posedge clk);
    lvl <= v;
    cyc(1);
  endtask
  task wreq(input logic u, input logic t);
    @(posedge clk);
    reg_write_req <= 1'b1;
    reg_write_unlock_field <= u;
    reg_write_reset_two_wire <= t;
    @(posedge clk);
    reg_write_req <= 1'b0;
    #1;
    a = reg_write_allow;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  initial begin
    {resetn, cfg_write, input_enable_bit, output_enable_bit, reg_write_req} = 5'h00;
    {nvm_input_enable_bit, nvm_output_enable_bit, nonvolatile_busy_status} = 3'h0;
    {window_comparator_result, reg_write_unlock_field, reg_write_reset_two_wire} = 3'h0;
    {nvm_input_function_code, nvm_output_function_code, input_function_code} = 12'h000;
    output_function_code = 4'h0;
    {nvm_input_channel_select, input_channel_select, channel_busy} = '0;
    lvl = 1'b1;
    do_reset(1'b1, 1'b0, GPI_DEEP_SLEEP);
    chk("boot_done", 8'h01, boot_done);
    edge_to(1'b0);
    chk("deep_sleep", 8'h00, deep_sleep);
    do_reset(1'b0, 1'b1, GPI_DEEP_SLEEP);
    chk("deep_sleep", 8'h01, deep_sleep);
    chk("sw_deep_sleep_disable", 8'h01, sw_deep_sleep_disable);
    edge_to(1'b1);
    chk("deep_sleep", 8'h00, deep_sleep);
    edge_to(1'b0);
    chk("deep_sleep", 8'h01, deep_sleep);
    edge_to(1'b1);
    for (int i = 0; i < 4; i++) begin
      setcfg(1'b1, 1'b0, pc[i], 4'h0, 3'h0);
      chk("sw_clear_disable", 8'(i == 2), sw_clear_disable);
      edge_to(1'b0);
      chk("fall pulses", 8'h01 << i & 8'h07,
          8'({output_clear_action, protect_pulse, fault_dump_pulse}));
      edge_to(1'b1);
      chk("rise pulses", 8'h00,
          8'({fault_dump_pulse, protect_pulse, output_clear_action}));
    end
    setcfg(1'b1, 1'b0, GPI_POWERDOWN, 4'h0, 3'h5);
    chk("sw_powerdown_disable", 8'h01, sw_powerdown_disable);
    edge_to(1'b0);
    chk("channel_powerdown", 8'h05, channel_powerdown);
    edge_to(1'b1);
    chk("channel_powerdown", 8'h00, channel_powerdown);
    setcfg(1'b1, 1'b0, GPI_SYNC_LOAD, 4'h0, 3'h3);
    chk("sw_sync_load_disable", 8'h01, sw_sync_load_disable);
    edge_to(1'b0);
    chk("synchronous_load_strobe", 8'h03, synchronous_load_strobe);
    edge_to(1'b1);
    chk("synchronous_load_strobe", 8'h00, synchronous_load_strobe);
    setcfg(1'b1, 1'b0, GPI_FUNC_GEN, 4'h0, 3'h6);
    chk("sw_func_gen_disable", 8'h01, sw_func_gen_disable);
    edge_to(1'b0);
    edge_to(1'b1);
    chk("func_gen_run", 8'h06, func_gen_run);
    edge_to(1'b0);
    chk("func_gen_run", 8'h00, func_gen_run);
    setcfg(1'b1, 1'b0, GPI_MARGIN, 4'h0, 3'h3);
    edge_to(1'b1);
    chk("margin_high", 8'h03, margin_high);
    edge_to(1'b0);
    chk("margin_low", 8'h03, margin_low);
    setcfg(1'b1, 1'b0, GPI_NVM_GATE, 4'h0, 3'h0);
    edge_to(1'b1);
    chk("nvm_program_allow", 8'h00, nvm_program_allow);
    edge_to(1'b0);
    chk("nvm_program_allow", 8'h01, nvm_program_allow);
    // both enables set: the pin is an output and its own toggling must not act as input
    setcfg(1'b1, 1'b1, GPI_CLEAR, GPO_WIN_CMP, 3'h0);
    @(posedge clk);
    window_comparator_result <= 1'b1;
    cyc(2);
    chk("shared_multi_pin_in", 8'h01, shared_multi_pin_in);
    @(posedge clk);
    window_comparator_result <= 1'b0;
    cyc(2);
    chk("shared_multi_pin_in", 8'h00, shared_multi_pin_in);
    chk("output_clear_action", 8'h00, output_clear_action);
    setcfg(1'b1, 1'b0, GPI_REG_GATE, 4'h0, 3'h0);
    edge_to(1'b1);
    wreq(1'b0, 1'b0);
    chk("reg_write_allow", 8'h00, a);
    wreq(1'b1, 1'b0);
    chk("reg_write_allow", 8'h01, a);
    wreq(1'b0, 1'b1);
    chk("reg_write_allow", 8'h01, a);
    edge_to(1'b0);
    wreq(1'b0, 1'b0);
    chk("reg_write_allow", 8'h01, a);
    for (int j = 0; j < 6; j++) begin
      setcfg(1'b0, 1'b1, 4'h0, oc[j], 3'h0);
      chk("shared_multi_pin_oe", 8'h01, shared_multi_pin_oe);
      for (int i = 0; i < 5; i++) begin
        @(posedge clk);
        {window_comparator_result, channel_busy[1], channel_busy[0], channel_busy[2],
         nonvolatile_busy_status} <= 5'h01 << i;
        cyc(2);
        chk("shared_multi_pin_out", 8'(i == j), shared_multi_pin_out);
      end
    end
    // volatile selection must not survive the reset
    setcfg(1'b1, 1'b0, GPI_CLEAR, 4'h0, 3'h0);
    do_reset(1'b1, 1'b1, GPI_FAULT_DUMP);
    edge_to(1'b0);
    chk("fault_dump_pulse", 8'h01, fault_dump_pulse);
    chk("output_clear_action", 8'h00, output_clear_action);
    do_reset(1'b1, 1'b1, GPI_RESET);
    edge_to(1'b0);
    chk("device_reset_pulse", 8'h01, device_reset_pulse);
    edge_to(1'b1);
    setcfg(1'b1, 1'b0, GPI_RESET, 4'h0, 3'h0);
    edge_to(1'b0);
    chk("device_reset_pulse", 8'h00, device_reset_pulse);
    stop_test;
  end
endmodule
bind multifunction_pin_mapper multifunction_pin_mapper_asserts #(.CH(CH)) chk_i (.*);
